// File: trb_bank.sv
// Top: register bank between software register port and offload engine/MAC
// Summary of operation
// - Config bit 0 drives engine reset low
// - Operation register drives select mode, echo enable
// - Local hardware address from low/high words
// - Remote hardware address input from two words
// - Local and remote network addresses registers
// - Timeout register drives engine timeout continuously
// - Command write gives code, one-cycle strobe
// - Local and remote port numbers, sixteen bits
// - Writing one clears sticky interrupt flag
// - Region below 0x100 is write-only
// - Output regions are read-only core views
// - Engine version register returns engine version
// - Status: init, open, state bits 20:16
// - Interrupt flag sticky until software clears
// - Cause register returns engine cause word
// - Remote address output readable as two words
// - MAC version register returns MAC version
// - MAC status bit 0 shows link up
// - Read answer two cycles after request
// - Writes update all bits, byte enables ignored
module trb_bank
	import trb_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [11:0] i_reg_addr,
	input wire logic i_reg_wr_en,
	input wire logic [31:0] i_reg_wr_data,
	input wire logic [3:0] i_write_byte_enables,
	input wire logic i_read_request,
	output logic [31:0] o_reg_rd_data,
	output logic o_read_valid,
	output logic o_engine_reset_n,
	output logic [1:0] o_remote_addr_select_mode,
	output logic o_resolve_echo_enable,
	output logic [47:0] o_local_hw_address,
	output logic [47:0] o_remote_hw_address_in,
	output logic [31:0] o_local_net_address,
	output logic [31:0] o_remote_net_address,
	output logic [31:0] o_timeout_value,
	output logic [1:0] o_connection_command_code,
	output logic o_connection_command_strobe,
	output logic [15:0] o_local_port,
	output logic [15:0] o_remote_port,
	input wire logic [31:0] i_engine_version,
	input wire logic i_init_done,
	input wire logic i_connection_open,
	input wire logic i_engine_interrupt,
	input wire logic [4:0] i_engine_state,
	input wire logic [31:0] i_interrupt_cause,
	input wire logic [47:0] i_remote_hw_address_out,
	input wire logic [31:0] i_mac_version,
	input wire logic i_mac_link_up
);
	// Byte enables are accepted but unused: all writes are full words
	logic [3:0] unused_be;
	assign unused_be = i_write_byte_enables;

	// Word-aligned offset and write decode
	logic [11:0] off;
	assign off = trb_word(i_reg_addr);
	logic wr_ok; // Write lands in the write-only region
	assign wr_ok = i_reg_wr_en && (off < WO_LIMIT);
	logic wr_rst, wr_opm, wr_lhl, wr_lhh, wr_rhl, wr_rhh;
	logic wr_lna, wr_rna, wr_tmo, wr_cmd, wr_lp, wr_rp, wr_icl;
	assign wr_rst = wr_ok && (off == OFF_RST);
	assign wr_opm = wr_ok && (off == OFF_OPM);
	assign wr_lhl = wr_ok && (off == OFF_LHA_LO);
	assign wr_lhh = wr_ok && (off == OFF_LHA_HI);
	assign wr_rhl = wr_ok && (off == OFF_RHI_LO);
	assign wr_rhh = wr_ok && (off == OFF_RHI_HI);
	assign wr_lna = wr_ok && (off == OFF_LNA);
	assign wr_rna = wr_ok && (off == OFF_RNA);
	assign wr_tmo = wr_ok && (off == OFF_TMO);
	assign wr_cmd = wr_ok && (off == OFF_CMD);
	assign wr_lp = wr_ok && (off == OFF_LPORT);
	assign wr_rp = wr_ok && (off == OFF_RPORT);
	assign wr_icl = wr_ok && (off == OFF_ICLR);

	// Engine outputs come from a foreign domain: two flops each
	logic [127:0] sa_r, sb_r; // Version, cause, remote address low, MAC ver
	logic [24:0] fa_r, fb_r; // Status bits and remote address high
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			sa_r <= '0;
			sb_r <= '0;
			fa_r <= '0;
			fb_r <= '0;
		end else begin
			sa_r <= {i_engine_version, i_interrupt_cause,
				i_remote_hw_address_out[31:0], i_mac_version};
			sb_r <= sa_r;
			fa_r <= {i_init_done, i_connection_open, i_engine_interrupt,
				i_engine_state, i_mac_link_up,
				i_remote_hw_address_out[47:32]};
			fb_r <= fa_r;
		end
	end
	logic [31:0] s_ever, s_cause, s_rho_lo, s_mver;
	assign {s_ever, s_cause, s_rho_lo, s_mver} = sb_r;
	logic s_init, s_conn, s_int, s_link;
	logic [4:0] s_state;
	logic [15:0] s_rho_hi;
	assign {s_init, s_conn, s_int, s_state, s_link, s_rho_hi} = fb_r;

	// Sticky interrupt flag: a new event wins over the clear
	logic int_flag_r, int_flag_nxt;
	assign int_flag_nxt = s_int ? 1'b1
		: ((wr_icl && i_reg_wr_data[0]) ? 1'b0 : int_flag_r);

	// Command strobe: one cycle per command write
	logic cmd_stb_nxt;
	assign cmd_stb_nxt = wr_cmd;

	// Configuration registers, cleared on reset so engine stays reset
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_engine_reset_n <= 1'b0;
			o_remote_addr_select_mode <= 2'h0;
			o_resolve_echo_enable <= 1'b0;
			o_local_hw_address <= 48'h0;
			o_remote_hw_address_in <= 48'h0;
			o_local_net_address <= RST_VAL;
			o_remote_net_address <= RST_VAL;
			o_timeout_value <= RST_VAL;
			o_connection_command_code <= 2'h0;
			o_connection_command_strobe <= 1'b0;
			o_local_port <= 16'h0;
			o_remote_port <= 16'h0;
			int_flag_r <= 1'b0;
		end else begin
			if (wr_rst) o_engine_reset_n <= i_reg_wr_data[0];
			if (wr_opm) begin
				o_remote_addr_select_mode <= i_reg_wr_data[1:0];
				o_resolve_echo_enable <= i_reg_wr_data[OPM_ECHO_BIT];
			end
			// Full-word writes, no byte lanes
			if (wr_lhl) o_local_hw_address[31:0] <= i_reg_wr_data;
			if (wr_lhh) o_local_hw_address[47:32] <= i_reg_wr_data[15:0];
			if (wr_rhl) o_remote_hw_address_in[31:0] <= i_reg_wr_data;
			if (wr_rhh) o_remote_hw_address_in[47:32] <= i_reg_wr_data[15:0];
			if (wr_lna) o_local_net_address <= i_reg_wr_data;
			if (wr_rna) o_remote_net_address <= i_reg_wr_data;
			if (wr_tmo) o_timeout_value <= i_reg_wr_data;
			if (wr_cmd) o_connection_command_code <= i_reg_wr_data[1:0];
			o_connection_command_strobe <= cmd_stb_nxt;
			if (wr_lp) o_local_port <= i_reg_wr_data[15:0];
			if (wr_rp) o_remote_port <= i_reg_wr_data[15:0];
			int_flag_r <= int_flag_nxt;
		end
	end

	// Status word assembly
	logic [31:0] sts_word;
	always_comb begin
		sts_word = '0;
		sts_word[STS_INIT_BIT] = s_init;
		sts_word[STS_CONN_BIT] = s_conn;
		sts_word[STS_INT_BIT] = int_flag_r;
		sts_word[STS_STATE_LSB +: 5] = s_state;
	end

	// Read mux: only output regions answer, all else reads zero
	logic [31:0] rd_sel;
	always_comb begin
		unique case (off)
			OFF_EVER: rd_sel = s_ever;
			OFF_ESTS: rd_sel = sts_word;
			OFF_ECAUSE: rd_sel = s_cause;
			OFF_RHO_LO: rd_sel = s_rho_lo;
			OFF_RHO_HI: rd_sel = {16'h0, s_rho_hi};
			OFF_MVER: rd_sel = s_mver;
			OFF_MSTS: rd_sel = {31'h0, s_link};
			default: rd_sel = '0;
		endcase
	end

	// Read latency pipeline
	trb_rd_if rd ();
	assign rd.req = i_read_request;
	assign rd.sel = rd_sel;
	trb_rd_pipe u_pipe (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.rd(rd)
	);
	// Answer comes straight from the pipeline flops: a further output
	// stage would stretch the read latency past two cycles
	assign o_read_valid = rd.valid;
	assign o_reg_rd_data = rd.data;

	// Checks kept next to the logic
	// Engine reset bit follows written bit 0
	property p_rst_bit;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_rst |=> o_engine_reset_n == $past(i_reg_wr_data[0]);
	endproperty : p_rst_bit
	a_rst_bit: assert property (p_rst_bit)
		else $error("engine reset bit not taken");
	// Engine reset only moves on its own register write
	property p_rst_hold;
		@(posedge i_ref_clk) disable iff (i_rst)
		!wr_rst |=> $stable(o_engine_reset_n);
	endproperty : p_rst_hold
	a_rst_hold: assert property (p_rst_hold)
		else $error("engine reset changed without a write");
	// Select mode and echo enable taken from their fields
	property p_opm;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_opm |=>
			o_resolve_echo_enable == $past(i_reg_wr_data[OPM_ECHO_BIT])
			&& o_remote_addr_select_mode == $past(i_reg_wr_data[1:0]);
	endproperty : p_opm
	a_opm: assert property (p_opm)
		else $error("operation fields wrong");
	// Local address low word stored whole
	property p_lha_lo;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_lhl |=> o_local_hw_address[31:0] == $past(i_reg_wr_data);
	endproperty : p_lha_lo
	a_lha_lo: assert property (p_lha_lo)
		else $error("local address low word wrong");
	// Local address high word keeps only the low half
	property p_lha;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_lhh |=>
			o_local_hw_address[47:32] == $past(i_reg_wr_data[15:0]);
	endproperty : p_lha
	a_lha: assert property (p_lha)
		else $error("local address high word wrong");
	// Remote address input low word stored whole
	property p_rhi_lo;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_rhl |=>
			o_remote_hw_address_in[31:0] == $past(i_reg_wr_data);
	endproperty : p_rhi_lo
	a_rhi_lo: assert property (p_rhi_lo)
		else $error("remote address low word wrong");
	// Remote address input high word keeps only the low half
	property p_rhi_hi;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_rhh |=>
			o_remote_hw_address_in[47:32] == $past(i_reg_wr_data[15:0]);
	endproperty : p_rhi_hi
	a_rhi_hi: assert property (p_rhi_hi)
		else $error("remote address high word wrong");
	// Local network address stored whole
	property p_lna;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_lna |=> o_local_net_address == $past(i_reg_wr_data);
	endproperty : p_lna
	a_lna: assert property (p_lna)
		else $error("local network address wrong");
	// Remote network address stored whole
	property p_rna;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_rna |=> o_remote_net_address == $past(i_reg_wr_data);
	endproperty : p_rna
	a_rna: assert property (p_rna)
		else $error("remote network address wrong");
	// Timeout taken from a full-word write
	property p_tmo;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_tmo |=> o_timeout_value == $past(i_reg_wr_data);
	endproperty : p_tmo
	a_tmo: assert property (p_tmo)
		else $error("timeout not stored");
	// Timeout stands between its own writes, stray writes included
	property p_tmo_hold;
		@(posedge i_ref_clk) disable iff (i_rst)
		!wr_tmo |=> $stable(o_timeout_value);
	endproperty : p_tmo_hold
	a_tmo_hold: assert property (p_tmo_hold)
		else $error("timeout changed without a write");
	// Strobe drops after a single command write
	property p_cmd;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_cmd ##1 !wr_cmd |=> !o_connection_command_strobe;
	endproperty : p_cmd
	a_cmd: assert property (p_cmd)
		else $error("command strobe longer than one cycle");
	// Every command write raises the strobe
	property p_cmd_on;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_cmd |=> o_connection_command_strobe;
	endproperty : p_cmd_on
	a_cmd_on: assert property (p_cmd_on)
		else $error("command strobe missing");
	// Command code presented with its strobe
	property p_cmd_code;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_cmd |=>
			o_connection_command_code == $past(i_reg_wr_data[1:0]);
	endproperty : p_cmd_code
	a_cmd_code: assert property (p_cmd_code)
		else $error("command code wrong");
	// Local port keeps the low half of the write
	property p_lport;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_lp |=> o_local_port == $past(i_reg_wr_data[15:0]);
	endproperty : p_lport
	a_lport: assert property (p_lport)
		else $error("local port wrong");
	// Remote port keeps the low half of the write
	property p_rport;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_rp |=> o_remote_port == $past(i_reg_wr_data[15:0]);
	endproperty : p_rport
	a_rport: assert property (p_rport)
		else $error("remote port wrong");
	// Flag holds unless a clear arrives
	property p_sticky;
		@(posedge i_ref_clk) disable iff (i_rst)
		int_flag_r && !(wr_icl && i_reg_wr_data[0]) |=> int_flag_r;
	endproperty : p_sticky
	a_sticky: assert property (p_sticky)
		else $error("interrupt flag dropped without clear");
	// An engine event always sets the flag, even against a clear
	property p_set;
		@(posedge i_ref_clk) disable iff (i_rst)
		s_int |=> int_flag_r;
	endproperty : p_set
	a_set: assert property (p_set)
		else $error("interrupt flag not set");
	// A clear with no new event empties the flag
	property p_clear;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_icl && i_reg_wr_data[0] && !s_int |=> !int_flag_r;
	endproperty : p_clear
	a_clear: assert property (p_clear)
		else $error("interrupt flag not cleared");
	// Answer strobe two edges after the request
	property p_lat;
		@(posedge i_ref_clk) disable iff (i_rst)
		i_read_request |-> ##2 o_read_valid;
	endproperty : p_lat
	a_lat: assert property (p_lat)
		else $error("read valid late");
	// Answer carries what was selected at the request edge
	property p_lat_data;
		@(posedge i_ref_clk) disable iff (i_rst)
		i_read_request |-> ##2 o_reg_rd_data == $past(rd_sel, 2);
	endproperty : p_lat_data
	a_lat_data: assert property (p_lat_data)
		else $error("read data not from request cycle");
	// Write-only region never reads back
	property p_wo;
		@(posedge i_ref_clk) disable iff (i_rst)
		off < WO_LIMIT |-> rd_sel == 32'h0;
	endproperty : p_wo
	a_wo: assert property (p_wo)
		else $error("write-only register readable");
endmodule : trb_bank

// File: trb_pkg.sv
// Package: register map, field positions and reset values of the test register bank
package trb_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_RST = 12'h000;
	localparam logic [11:0] OFF_OPM = 12'h004;
	localparam logic [11:0] OFF_LHA_LO = 12'h008;
	localparam logic [11:0] OFF_LHA_HI = 12'h00C;
	localparam logic [11:0] OFF_RHI_LO = 12'h010;
	localparam logic [11:0] OFF_RHI_HI = 12'h014;
	localparam logic [11:0] OFF_LNA = 12'h018;
	localparam logic [11:0] OFF_RNA = 12'h01C;
	localparam logic [11:0] OFF_TMO = 12'h020;
	localparam logic [11:0] OFF_CMD = 12'h040;
	localparam logic [11:0] OFF_LPORT = 12'h044;
	localparam logic [11:0] OFF_RPORT = 12'h048;
	localparam logic [11:0] OFF_ICLR = 12'h080;
	localparam logic [11:0] OFF_EVER = 12'h100;
	localparam logic [11:0] OFF_ESTS = 12'h104;
	localparam logic [11:0] OFF_ECAUSE = 12'h108;
	localparam logic [11:0] OFF_RHO_LO = 12'h10C;
	localparam logic [11:0] OFF_RHO_HI = 12'h110;
	localparam logic [11:0] OFF_MVER = 12'h200;
	localparam logic [11:0] OFF_MSTS = 12'h204;
	// Write-only region ends below this offset
	localparam logic [11:0] WO_LIMIT = 12'h100;
	localparam int RD_LAT = 2;
	localparam int STS_INIT_BIT = 0;
	localparam int STS_CONN_BIT = 1;
	localparam int STS_INT_BIT = 2;
	localparam int STS_STATE_LSB = 16;
	localparam int OPM_ECHO_BIT = 16;
	localparam logic [31:0] RST_VAL = 32'h0000_0000;
	// Byte address to word-aligned offset: low two bits dropped
	function automatic logic [11:0] trb_word(input logic [11:0] a);
		return {a[11:2], 2'b00};
	endfunction : trb_word
endpackage : trb_pkg

// File: trb_rd_if.sv
// Interface: read request, selected data and delayed answer
interface trb_rd_if;
	import trb_pkg::*;
	logic req; // Read request
	logic [31:0] sel; // Selected data
	logic [31:0] data; // Answer data
	logic valid; // Answer strobe
	modport src (output req, output sel, input data, input valid);
	modport pipe (input req, input sel, output data, output valid);
endinterface : trb_rd_if

// File: trb_rd_pipe.sv
// Two-stage read pipeline giving the read answer its fixed latency
module trb_rd_pipe
	import trb_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	trb_rd_if.pipe rd
);
	logic req_d_r; // First delay stage of the request
	logic [31:0] sel_d_r; // Data held with that stage
	logic valid_r; // Second stage, the answer strobe
	logic [31:0] data_r; // Answer data

	// Request delayed through two flops
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			req_d_r <= 1'b0;
			valid_r <= 1'b0;
			sel_d_r <= RST_VAL;
			data_r <= RST_VAL;
		end else begin
			req_d_r <= rd.req;
			valid_r <= req_d_r;
			sel_d_r <= rd.sel;
			data_r <= sel_d_r;
		end
	end

	assign rd.valid = valid_r;
	assign rd.data = data_r;

	// Strobe follows the request by exactly two edges
	property p_two_cycle;
		@(posedge i_ref_clk) disable iff (i_rst)
		rd.req |-> ##2 rd.valid;
	endproperty : p_two_cycle
	a_two_cycle: assert property (p_two_cycle)
		else $error("read valid not two cycles after request");
endmodule : trb_rd_pipe

// File: trb_core_model.sv
// Behavioural model of the offload engine and MAC status side
module trb_core_model #(
	parameter logic [31:0] ENG_VER = 32'h0000_0102, // Arbitrary value
	parameter logic [31:0] MAC_VER = 32'h0000_0201 // Arbitrary value
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_engine_reset_n,
	input wire logic [1:0] i_command_code,
	input wire logic i_command_strobe,
	input wire logic [47:0] i_remote_hw_address_in,
	output logic [31:0] o_engine_version,
	output logic o_init_done,
	output logic o_connection_open,
	output logic o_engine_interrupt,
	output logic [4:0] o_engine_state,
	output logic [31:0] o_interrupt_cause,
	output logic [47:0] o_remote_hw_address_out,
	output logic [31:0] o_mac_version,
	output logic o_mac_link_up
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] boot_r; // Start-up count after engine reset release
	assign o_engine_version = ENG_VER;
	assign o_mac_version = MAC_VER;
	// Engine: idle in reset, boots, then answers each command
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || !i_engine_reset_n) begin
			boot_r <= 3'h0;
			o_init_done <= 1'b0;
			o_engine_interrupt <= 1'b0;
			o_engine_state <= 5'h00;
			o_interrupt_cause <= 32'h0000_0000;
			o_connection_open <= 1'b0;
		end else begin
			if (boot_r != 3'h4) boot_r <= boot_r + 3'h1;
			o_init_done <= (boot_r == 3'h4);
			// Interrupt is a one-cycle pulse, so the bank must hold it
			o_engine_interrupt <= i_command_strobe;
			if (i_command_strobe) begin
				o_engine_state <= {3'h0, i_command_code};
				o_interrupt_cause <= {30'h0, i_command_code} + 32'h0000_0010;
				o_connection_open <= (i_command_code == 2'h1);
			end
		end
		// Inverted echo so a pass-through of the input cannot match
		o_remote_hw_address_out <= ~i_remote_hw_address_in;
		o_mac_link_up <= !i_rst;
	end
endmodule : trb_core_model

// File: trb_bank_tb.sv
// Self-checking testbench of the test register bank
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	bad_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module trb_bank_tb;
	import trb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, wen = 0, rreq = 0, strb, rval, rstn, echo;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdat = 32'h0, rdat, ever, mver, cause, lna, rna, tmo, got;
	logic [3:0] ben = 4'h0;
	logic [1:0] mode, code;
	logic [47:0] lha, rhi, rho;
	logic [15:0] lport, rport;
	logic [4:0] est;
	logic init, conn, eint, link;
	int bad_count = 0, checks_done = 0, cycles = 0;
	logic [11:0] ofs [10] = '{OFF_RST, OFF_OPM, OFF_LHA_LO, OFF_LHA_HI,
		OFF_RHI_LO, OFF_RHI_HI, OFF_LNA, OFF_RNA, OFF_TMO, OFF_LPORT};
	logic [31:0] val [10] = '{32'h1, 32'h0001_0002, 32'h1111_2222,
		32'hABCD_0077, 32'h3333_4444, 32'h0000_5555, 32'hC0A8_0001,
		32'hC0A8_0002, 32'h0000_1234, 32'hFFFF_1F90};
	logic [11:0] rofs [9] = '{OFF_EVER, OFF_ECAUSE, OFF_RHO_LO, OFF_RHO_HI,
		OFF_MVER, OFF_MSTS, OFF_TMO, 12'h300, 12'h0FC};
	logic [31:0] rexp [9] = '{32'h0000_0102, 32'h11, 32'hCCCC_BBBB,
		32'h0000_AAAA, 32'h0000_0201, 32'h1, 32'h0, 32'h0, 32'h0};
	logic [1:0] cmds [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
	trb_bank uut (.i_ref_clk(clk), .i_rst(rst), .i_reg_addr(addr),
		.i_reg_wr_en(wen), .i_reg_wr_data(wdat), .i_write_byte_enables(ben),
		.i_read_request(rreq), .o_reg_rd_data(rdat), .o_read_valid(rval),
		.o_engine_reset_n(rstn), .o_remote_addr_select_mode(mode),
		.o_resolve_echo_enable(echo), .o_local_hw_address(lha),
		.o_remote_hw_address_in(rhi), .o_local_net_address(lna),
		.o_remote_net_address(rna), .o_timeout_value(tmo),
		.o_connection_command_code(code), .o_connection_command_strobe(strb),
		.o_local_port(lport), .o_remote_port(rport), .i_engine_version(ever),
		.i_init_done(init), .i_connection_open(conn), .i_engine_interrupt(eint),
		.i_engine_state(est), .i_interrupt_cause(cause),
		.i_remote_hw_address_out(rho), .i_mac_version(mver),
		.i_mac_link_up(link));
	trb_core_model core (.i_ref_clk(clk), .i_rst(rst), .i_engine_reset_n(rstn),
		.i_command_code(code), .i_command_strobe(strb),
		.i_remote_hw_address_in(rhi), .o_engine_version(ever),
		.o_init_done(init), .o_connection_open(conn),
		.o_engine_interrupt(eint), .o_engine_state(est),
		.o_interrupt_cause(cause), .o_remote_hw_address_out(rho),
		.o_mac_version(mver), .o_mac_link_up(link));
	// Clock of 5 ns period
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Hang guard: far above the hundred or so cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	// One write; byte enables left as they stand since they must not matter
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wen <= 1'b1;
		@(posedge clk);
		wen <= 1'b0;
		#1;
	endtask : wr
	// One read; address held until the answer arrives
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		int n;
		@(posedge clk);
		addr <= a;
		rreq <= 1'b1;
		@(posedge clk);
		rreq <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (rval !== 1'b1 && n < 10);
		// Count starts after the edge that samples the request, so it reads one edge short
		`CHK("latency", RD_LAT - 1, n)
		d = rdat;
	endtask : rd
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("reset_n", 1'b0, rstn)
		`CHK("lha", 48'h0, lha)
		for (int i = 0; i < 10; i++) wr(ofs[i], val[i]);
		`CHK("reset_n", 1'b1, rstn)
		`CHK("opm", 3'b101, {mode, echo})
		`CHK("lha", 48'h0077_1111_2222, lha)
		`CHK("rhi", 48'h5555_3333_4444, rhi)
		`CHK("na", 64'hC0A8_0001_C0A8_0002, {lna, rna})
		`CHK("tmo", 32'h1234, tmo)
		// Only lane 0 enabled from here on, yet whole words must land
		@(posedge clk);
		ben <= 4'h1;
		wr(OFF_RPORT, 32'h0001_8050);
		`CHK("ports", 32'h1F90_8050, {lport, rport})
		// Bad writes: unmapped gap, top of write region, read-only view
		wr(12'h024, 32'hFFFF_FFFF);
		wr(12'h0FC, 32'hFFFF_FFFF);
		wr(OFF_EVER, 32'h0);
		`CHK("tmo", 32'h1234, tmo)
		for (int i = 0; i < 4; i++) begin
			wr(OFF_CMD, {30'h3FFF_FFFF, cmds[i]});
			`CHK("strobe", 3'b100 | cmds[i], {strb, code})
			@(posedge clk);
			#1;
			`CHK("strobe", 1'b0, strb)
		end
		repeat (6) @(posedge clk);
		for (int i = 0; i < 9; i++) begin
			rd(rofs[i], got);
			`CHK("read", rexp[i], got)
		end
		rd(OFF_ESTS, got);
		`CHK("status", 32'h0001_0007, got)
		wr(OFF_ICLR, 32'hFFFF_FFFE);
		rd(OFF_ESTS, got);
		`CHK("status", 32'h0001_0007, got)
		wr(OFF_ICLR, 32'h1);
		rd(OFF_ESTS, got);
		`CHK("status", 32'h0001_0003, got)
		// Second reset in mid-run
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("cfg", 33'h0, {rstn, lport, rport})
		rd(OFF_ESTS, got);
		`CHK("status", 32'h0, got)
		give_verdict();
	end
endmodule : trb_bank_tb
